/* shared/health_pkg.sv */
// Shared constants and types for the health and status reporter.
package health_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00; // Mode, altitude source and altitude.
  localparam logic [7:0] OFF_ADDRESS  = 8'h04; // Aircraft address.
  localparam logic [7:0] OFF_POWERUP  = 8'h08; // Power-up test results.
  localparam logic [7:0] OFF_CPU_RES  = 8'h0C; // Processor test numeric result.
  localparam logic [7:0] OFF_WDOG     = 8'h10; // Watchdog service, any write.
  localparam logic [7:0] OFF_ACK_STAT = 8'h14; // Current acknowledge contents.
  localparam logic [7:0] OFF_CONT     = 8'h18; // Continuous test failure vector.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;  // Two-bit operating mode.
  localparam int CTRL_ALT_SRC  = 2;  // One selects the internal altitude source.
  localparam int CTRL_ALT_LSB  = 16; // Sixteen-bit altitude value.
  localparam int PU_DONE       = 0;  // Software has finished the power-up tests.
  localparam int PU_RAM_OK     = 1;  // Working memory walking-ones test passed.
  localparam int PU_ROM_OK     = 2;  // Read-only memory test passed.
  localparam int PU_IO_OK      = 3;  // Input/output test passed.
  localparam int PU_TIMING_OK  = 4;  // Timing test passed.
  localparam int PU_CRC_OK     = 5;  // All image and parameter CRCs passed.
  localparam int PU_CAL_OK     = 6;  // Calibration checksum passed.
  localparam int NUM_CONT      = 9;  // Number of continuous tests besides the position feed.

  // Status byte zero bit positions.
  localparam int SB_POWERUP = 7;
  localparam int SB_CONT    = 6;
  localparam int SB_CPU     = 4;
  localparam int SB_CRC     = 3;
  localparam int SB_RAM     = 2;
  localparam int SB_CAL     = 1;

  // ----------------------------------------------------------------
  // Message and timing constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  MSG_STATUS_REQ  = 8'h83;       // Detailed status request type.
  localparam logic [31:0] CPU_EXPECTED    = 32'h5A3C96E1; // Processor test answer.
  localparam logic [23:0] ADDR_ALL_ONES   = 24'hFFFFFF;   // Invalid aircraft address.
  localparam int          CLK_HZ          = 20000000;     // Clock rate.
  localparam int          GPS_PERIOD_MS   = 1000;         // Longest gap between fixes.
  localparam int          WDOG_PERIOD_MS  = 100;          // Longest gap between services.
  localparam int          GPS_CYCLES      = (CLK_HZ / 1000) * GPS_PERIOD_MS;
  localparam int          WDOG_CYCLES     = (CLK_HZ / 1000) * WDOG_PERIOD_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_ON, MODE_ALT} mode_type;

  // Pins from the rest of the unit, all asynchronous to mclk.
  typedef struct packed {
    logic rx1_ok;      // First receiver healthy.
    logic rx2_ok;      // Second receiver healthy.
    logic hv_ok;       // Transmitter high-voltage supply in range.
    logic parity_err;  // Memory parity error seen.
    logic upset_err;   // Logic configuration upset seen.
    logic supply_ok;   // Input supply voltage in range.
    logic temp_ok;     // Internal temperature in range.
    logic gps_pulse;   // Rising edge marks each position fix; falling edges are ignored.
    logic weight_on_wheels_input;
    logic service_mode_input;
  } pin_type;

  // Acknowledge or detailed status message to the host.
  typedef struct packed {
    logic        detail;       // One for a detailed status response.
    logic        unit_fail_flag;
    logic        sys_fail;
    mode_type    mode;
    logic        alt_internal;
    logic [15:0] altitude;
    logic        weight_on_wheels;
    logic        service_mode;
    logic [7:0]  selftest_byte_zero;
  } ack_msg_type;

endpackage

/* verilog/health_status_reporter.sv */
// Health and self-test status aggregation with acknowledge generation.
//
// How it works
// - Every host message gets an acknowledge.
// - System fail on GPS, address, supply loss.
// - Unit fail hidden while mode is off.
// - Acknowledge carries mode, altitude and discretes.
// - Type 0x83 request answered with detail.
// - Detail holds power-up and continuous results.
// - Bit 7 flags any power-up failure.
// - Power-up covers memories, IO, timing, processor, calibration.
// - Power-up failure latches until power cycle.
// - Bit 6 flags any continuous failure.
// - Continuous failure drives unit or system fail.
// - Continuous bit clears when all pass again.
// - Watchdog, parity, upset failures reset processor if none already active.
// - Bit 4 is logic-checked processor test verdict.
// - Bit 3 reports image and parameter CRCs.
// - Bit 2 reports walking-ones memory test.
// - Bit 1 set only with good calibration.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns

module health_status_reporter #(
  parameter int GPS_TIMEOUT  = health_pkg::GPS_CYCLES,  // Cycles without a fix.
  parameter int WDOG_TIMEOUT = health_pkg::WDOG_CYCLES  // Cycles without a service.
) (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    srst,
  // APB register port.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Host message decoder, same clock.
  input  wire logic                    msg_valid,
  input  wire logic [7:0]              msg_type,
  // Health pins from the unit.
  input  wire health_pkg::pin_type     pins,
  // Answer to the host and processor reset.
  output health_pkg::ack_msg_type      ack_msg,
  output logic                         ack_valid,
  output logic                         cpu_reset
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  health_pkg::pin_type pins_meta_r;  // First stage, read only by the second.
  health_pkg::pin_type pins_r;       // Second stage, safe to use.
  logic                gps_prev_r;   // Previous fix level for edge detection.

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge mclk) begin
    pins_meta_r <= pins;
    pins_r      <= pins_meta_r;
    gps_prev_r  <= pins_r.gps_pulse;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  wire logic setup_phase  = psel & ~penable;           // First cycle of a transfer.
  wire logic access_done  = psel & penable & pready;   // Edge at which the transfer ends.
  wire logic wr_done      = access_done & pwrite;      // Write takes effect here.
  wire logic hit_ctrl     = (paddr == health_pkg::OFF_CTRL);
  wire logic hit_address  = (paddr == health_pkg::OFF_ADDRESS);
  wire logic hit_powerup  = (paddr == health_pkg::OFF_POWERUP);
  wire logic hit_cpu      = (paddr == health_pkg::OFF_CPU_RES);
  wire logic hit_wdog     = (paddr == health_pkg::OFF_WDOG);
  wire logic hit_ack      = (paddr == health_pkg::OFF_ACK_STAT);
  wire logic hit_cont     = (paddr == health_pkg::OFF_CONT);
  wire logic mapped       = hit_ctrl | hit_address | hit_powerup | hit_cpu | hit_wdog
                            | hit_ack | hit_cont;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------

  logic [31:0] ctrl_r;        // Mode, source and altitude.
  logic [23:0] address_r;     // Aircraft address.
  logic [6:0]  powerup_r;     // Power-up results as written by software.
  logic        cpu_checked_r; // Processor result has been checked.
  logic        cpu_ok_r;      // Processor result matched the expected answer.

  // Register writes take effect only at the completing access edge.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r        <= 32'h00000000;
      address_r     <= 24'h000000;
      powerup_r     <= 7'h00;
      cpu_checked_r <= 1'b0;
      cpu_ok_r      <= 1'b0;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata;
      end
      if (hit_address) begin
        address_r <= pwdata[23:0];
      end
      if (hit_powerup) begin
        powerup_r <= pwdata[6:0];
      end
      if (hit_cpu) begin
        cpu_checked_r <= 1'b1;
        cpu_ok_r      <= (pwdata == health_pkg::CPU_EXPECTED);
      end
    end
  end

  // Decoded control fields.
  wire health_pkg::mode_type mode = health_pkg::mode_type'(ctrl_r[health_pkg::CTRL_MODE_LSB +: 2]);
  wire logic                 alt_internal = ctrl_r[health_pkg::CTRL_ALT_SRC];
  wire logic [15:0]          altitude     = ctrl_r[health_pkg::CTRL_ALT_LSB +: 16];

  // ----------------------------------------------------------------
  // Power-up tests
  // ----------------------------------------------------------------

  // Every power-up test must report a pass for the group to pass.
  wire logic pu_done    = powerup_r[health_pkg::PU_DONE];
  wire logic pu_all_ok  = powerup_r[health_pkg::PU_RAM_OK] & powerup_r[health_pkg::PU_ROM_OK]
                          & powerup_r[health_pkg::PU_IO_OK] & powerup_r[health_pkg::PU_TIMING_OK]
                          & powerup_r[health_pkg::PU_CRC_OK] & powerup_r[health_pkg::PU_CAL_OK]
                          & cpu_ok_r;
  wire logic pu_failing = (pu_done & ~pu_all_ok) | (cpu_checked_r & ~cpu_ok_r);

  logic pwrup_fail_r; // Latched power-up failure.

  // Once set, only a power cycle (reset) clears the power-up failure.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pwrup_fail_r <= 1'b0;
    end else if (pu_failing) begin
      pwrup_fail_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Continuous tests
  // ----------------------------------------------------------------

  logic [31:0] gps_cnt_r;   // Cycles since the last position fix.
  logic [31:0] wdog_cnt_r;  // Cycles since the last watchdog service.
  logic        gps_lost_r;  // Position feed is too slow.
  logic        wdog_lost_r; // Watchdog not serviced in time.

  wire logic gps_edge   = pins_r.gps_pulse & ~gps_prev_r;
  wire logic wdog_kick  = wr_done & hit_wdog;

  // Gap counters for the position feed and watchdog; a fresh event clears the fault.
  always_ff @(posedge mclk) begin
    if (srst) begin
      gps_cnt_r   <= 32'h00000000;
      wdog_cnt_r  <= 32'h00000000;
      gps_lost_r  <= 1'b0;
      wdog_lost_r <= 1'b0;
    end else begin
      if (gps_edge) begin
        gps_cnt_r  <= 32'h00000000;
        gps_lost_r <= 1'b0;
      end else if (gps_cnt_r >= 32'(GPS_TIMEOUT - 1)) begin
        gps_lost_r <= 1'b1;
      end else begin
        gps_cnt_r <= gps_cnt_r + 32'h00000001;
      end
      if (wdog_kick) begin
        wdog_cnt_r  <= 32'h00000000;
        wdog_lost_r <= 1'b0;
      end else if (wdog_cnt_r >= 32'(WDOG_TIMEOUT - 1)) begin
        wdog_lost_r <= 1'b1;
      end else begin
        wdog_cnt_r <= wdog_cnt_r + 32'h00000001;
      end
    end
  end

  // An all-zero or all-one aircraft address is not valid.
  wire logic addr_bad = (address_r == 24'h000000) | (address_r == health_pkg::ADDR_ALL_ONES);

  // Failing tests, unit faults in the upper bits, system faults in the lower two.
  wire logic [health_pkg::NUM_CONT-1:0] cont_now = {
    ~pins_r.rx1_ok,
    ~pins_r.rx2_ok,
    wdog_lost_r,
    ~pins_r.hv_ok,
    pins_r.parity_err,
    pins_r.upset_err,
    ~pins_r.temp_ok,
    addr_bad,
    ~pins_r.supply_ok
  };

  logic [health_pkg::NUM_CONT-1:0] cont_r; // Registered failure vector.
  logic                            gps_r;  // Registered position feed loss.

  // Each failure holds while its test fails and drops when the test passes again.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cont_r <= '0;
      gps_r  <= 1'b0;
    end else begin
      cont_r <= cont_now;
      gps_r  <= gps_lost_r;
    end
  end

  // Split into unit-related and system-related failures.
  wire logic unit_cont = |cont_r[health_pkg::NUM_CONT-1:2];
  wire logic sys_cont  = |cont_r[1:0] | gps_r;
  wire logic cont_fail = unit_cont | sys_cont;

  // Unit failures are shown only outside the off mode; system failures are always shown.
  wire logic annunciate = (mode != health_pkg::MODE_OFF);
  wire logic unit_fail  = annunciate & (pwrup_fail_r | unit_cont);
  wire logic sys_fail   = sys_cont;

  // ----------------------------------------------------------------
  // Processor reset
  // ----------------------------------------------------------------

  // Watchdog, parity and configuration faults each warrant a restart.
  wire logic crit_fail = wdog_lost_r | pins_r.parity_err | pins_r.upset_err;

  logic crit_prev_r; // Critical fault level one cycle ago.
  logic cpu_reset_r; // One-cycle processor reset pulse.

  // Pulse once each time the combined critical fault level rises.
  always_ff @(posedge mclk) begin
    if (srst) begin
      crit_prev_r <= 1'b0;
      cpu_reset_r <= 1'b0;
    end else begin
      crit_prev_r <= crit_fail;
      cpu_reset_r <= crit_fail & ~crit_prev_r;
    end
  end

  // ----------------------------------------------------------------
  // Status byte zero
  // ----------------------------------------------------------------

  // Pass bits read one only once their test has run and passed.
  wire logic [7:0] status0;
  assign status0[health_pkg::SB_POWERUP] = pwrup_fail_r;
  assign status0[health_pkg::SB_CONT]    = cont_fail;
  assign status0[5]                      = 1'b0;
  assign status0[health_pkg::SB_CPU]     = cpu_checked_r & cpu_ok_r;
  assign status0[health_pkg::SB_CRC]     = pu_done & powerup_r[health_pkg::PU_CRC_OK];
  assign status0[health_pkg::SB_RAM]     = pu_done & powerup_r[health_pkg::PU_RAM_OK];
  assign status0[health_pkg::SB_CAL]     = pu_done & powerup_r[health_pkg::PU_CAL_OK];
  assign status0[0]                      = 1'b0;

  // ----------------------------------------------------------------
  // Acknowledge generation
  // ----------------------------------------------------------------

  health_pkg::ack_msg_type ack_nxt;   // Message built from current state.
  health_pkg::ack_msg_type ack_r;     // Last message sent.
  logic                    ack_valid_r; // One-cycle strobe with each message.

  // Assemble the message; a status request also gets the detail byte.
  always_comb begin
    ack_nxt                    = '0;
    ack_nxt.detail             = (msg_type == health_pkg::MSG_STATUS_REQ);
    ack_nxt.unit_fail_flag     = unit_fail;
    ack_nxt.sys_fail           = sys_fail;
    ack_nxt.mode               = mode;
    ack_nxt.alt_internal       = alt_internal;
    ack_nxt.altitude           = altitude;
    ack_nxt.weight_on_wheels   = pins_r.weight_on_wheels_input;
    ack_nxt.service_mode       = pins_r.service_mode_input;
    ack_nxt.selftest_byte_zero = ack_nxt.detail ? status0 : 8'h00;
  end

  // Every received message is answered the next cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_r       <= '0;
      ack_valid_r <= 1'b0;
    end else begin
      ack_valid_r <= msg_valid;
      if (msg_valid) begin
        ack_r <= ack_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read path and response
  // ----------------------------------------------------------------

  // Read data selected by address.
  wire logic [31:0] rd_mux =
      hit_ctrl    ? ctrl_r :
      hit_address ? {8'h00, address_r} :
      hit_powerup ? {25'h0000000, powerup_r} :
      hit_cpu     ? {30'h00000000, cpu_ok_r, cpu_checked_r} :
      hit_ack     ? {22'h000000, unit_fail, sys_fail, status0} :
      hit_cont    ? {22'h000000, gps_r, cont_r} :
      32'h00000000;

  logic [31:0] prdata_r;  // Read data captured in the setup cycle.
  logic        pready_r;  // Ready in the access cycle, zero wait states.
  logic        pslverr_r; // Error for unmapped addresses.

  // Capture the answer during setup so that it is stable for the access phase.
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_phase;
      pslverr_r <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign ack_msg   = ack_r;
  assign ack_valid = ack_valid_r;
  assign cpu_reset = cpu_reset_r;

endmodule

/* test/health_status_reporter_asserts.sv */
// Port-level assertions for the health and status reporter.
`timescale 1ns/1ns
module health_status_asserts (
  // Clock and reset.
  input wire logic                    mclk,
  input wire logic                    srst,
  // Host messages, pins and answers.
  input wire logic                    msg_valid,
  input wire logic [7:0]              msg_type,
  input wire health_pkg::pin_type     pins,
  input wire health_pkg::ack_msg_type ack_msg,
  input wire logic                    ack_valid,
  input wire logic                    cpu_reset
);
  // ------------------------------------------------------------
  // Message and status checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic pu_seen_r; // A detailed answer has already shown a power-up failure.
  // Remember a reported power-up failure until reset.
  always_ff @(posedge mclk) begin
    if (srst) pu_seen_r <= 1'b0;
    else if (ack_valid && ack_msg.detail && ack_msg.selftest_byte_zero[7]) pu_seen_r <= 1'b1;
  end
  property p_answer; msg_valid |=> ack_valid; endproperty
  a_answer: assert property (p_answer) else $error("Message left unanswered.");
  property p_cause; ack_valid |-> $past(msg_valid); endproperty
  a_cause: assert property (p_cause) else $error("Answer without a message.");
  property p_hold; !msg_valid |=> $stable(ack_msg); endproperty
  a_hold: assert property (p_hold) else $error("Answer changed with no message.");
  property p_off; ack_valid && ack_msg.mode == health_pkg::MODE_OFF |-> !ack_msg.unit_fail_flag;
  endproperty
  a_off: assert property (p_off) else $error("Unit fail shown in off mode.");
  property p_detail;
    ack_valid |-> ack_msg.detail == ($past(msg_type) == health_pkg::MSG_STATUS_REQ);
  endproperty
  a_detail: assert property (p_detail) else $error("Wrong answer kind.");
  property p_reserved;
    ack_valid |-> !ack_msg.selftest_byte_zero[5] && !ack_msg.selftest_byte_zero[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set.");
  property p_pwrup; ack_valid && ack_msg.detail && ack_msg.selftest_byte_zero[7]
    && ack_msg.mode != health_pkg::MODE_OFF |-> ack_msg.unit_fail_flag; endproperty
  a_pwrup: assert property (p_pwrup) else $error("Power-up fail not in unit fail.");
  property p_latch; ack_valid && ack_msg.detail && pu_seen_r |-> ack_msg.selftest_byte_zero[7];
  endproperty
  a_latch: assert property (p_latch) else $error("Power-up fail cleared.");
  property p_cont; ack_valid && ack_msg.detail && ack_msg.selftest_byte_zero[6]
    && ack_msg.mode != health_pkg::MODE_OFF |-> ack_msg.unit_fail_flag || ack_msg.sys_fail;
  endproperty
  a_cont: assert property (p_cont) else $error("Continuous fail not flagged.");
  property p_reset; $rose(pins.parity_err) |-> ##[2:6] cpu_reset; endproperty
  a_reset: assert property (p_reset) else $error("Parity error without reset.");
  c_detail: cover property (ack_valid && ack_msg.detail);
  c_off: cover property (ack_valid && ack_msg.mode == health_pkg::MODE_OFF && ack_msg.sys_fail);
  c_reset: cover property (cpu_reset);
endmodule
bind health_status_reporter health_status_asserts i_health_status_asserts (.mclk(mclk),
  .srst(srst), .msg_valid(msg_valid),
  .msg_type(msg_type), .pins(pins), .ack_msg(ack_msg), .ack_valid(ack_valid),
  .cpu_reset(cpu_reset));

/* test/host_model.sv */
// Behavioural host computer that frames one message per bench request.
`timescale 1ns/1ns
module host_model (
  // Clock, reset and bench request.
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       send,
  input  wire logic [7:0] send_type,
  // Message strobe toward the reporter.
  output logic            msg_valid,
  output logic [7:0]      msg_type
);
  // One-cycle strobe per request; the type field wanders between messages.
  always_ff @(posedge mclk) begin
    if (srst) begin
      msg_valid <= 1'b0;
      msg_type  <= 8'hA5;
    end else begin
      msg_valid <= send;
      msg_type  <= send ? send_type : ~msg_type;
    end
  end
endmodule

/* test/test_health_status_reporter.sv */
// Self-checking bench for the health and status reporter.
`timescale 1ns/1ns
module test_health_status_reporter;
  localparam int GPS_T  = 200;  // Shortened fix timeout.
  localparam int WDOG_T = 3000; // Shortened watchdog timeout.
  logic                    mclk = 1'b0, srst = 1'b1, send = 1'b0, gps_on = 1'b1;
  logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
  logic [7:0]              paddr = 8'h00, send_type = 8'h00, msg_type;
  logic [31:0]             pwdata = 32'h00000000, prdata, rdata;
  logic                    pready, pslverr, msg_valid, ack_valid, cpu_reset;
  health_pkg::pin_type     pins = 10'h398; // All tests passing.
  health_pkg::ack_msg_type ack_msg, e;
  int                      err_total = 0, comparisons = 0, mode, resets = 0, exp_resets = 0;
  logic                    alt_int, addr_ok, pu_fail, cpu_ok, gps_lost = 1'b0, wdog_bad;
  logic [15:0]             alt;
  logic [6:0]              pu_w; // Last power-up word written.
  health_status_reporter #(.GPS_TIMEOUT(GPS_T), .WDOG_TIMEOUT(WDOG_T)) i_health_status_reporter (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_valid(msg_valid), .msg_type(msg_type), .pins(pins), .ack_msg(ack_msg),
    .ack_valid(ack_valid), .cpu_reset(cpu_reset));
  host_model i_host_model (.mclk(mclk), .srst(srst), .send(send), .send_type(send_type),
    .msg_valid(msg_valid), .msg_type(msg_type));
  initial forever #25 mclk = ~mclk;
  // Toggle the fix line while the feed runs; count processor reset pulses.
  initial forever begin
    repeat (40) @(posedge mclk);
    if (gps_on) pins.gps_pulse <= ~pins.gps_pulse;
  end
  always @(posedge mclk) if (!srst && cpu_reset === 1'b1) resets <= resets + 1;
  // Reference answer built from the bench's own view of the unit.
  function automatic health_pkg::ack_msg_type model(input logic [7:0] t);
    health_pkg::ack_msg_type r;
    logic uf;
    logic sf;
    uf = !pins.rx1_ok || !pins.rx2_ok || !pins.hv_ok || pins.parity_err || pins.upset_err
         || !pins.temp_ok || wdog_bad;
    sf = gps_lost || !addr_ok || !pins.supply_ok;
    r.detail             = (t == health_pkg::MSG_STATUS_REQ);
    r.unit_fail_flag     = (mode != 0) && (pu_fail || uf);
    r.sys_fail           = sf;
    r.mode               = health_pkg::mode_type'(mode);
    r.alt_internal       = alt_int;
    r.altitude           = alt;
    r.weight_on_wheels   = pins.weight_on_wheels_input;
    r.service_mode       = pins.service_mode_input;
    r.selftest_byte_zero = r.detail ? {pu_fail, uf || sf, 1'b0, cpu_ok, pu_w[5] & pu_w[0],
                           pu_w[1] & pu_w[0], pu_w[6] & pu_w[0], 1'b0} : 8'h00;
    return r;
  endfunction
  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string m);
    comparisons++;
    if (g !== x) fail(m);
  endtask
  task automatic cmp_ack(input health_pkg::ack_msg_type x);
    comparisons++;
    if (ack_msg !== x) fail($sformatf("answer %h not %h", ack_msg, x));
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for pready or ack_valid at a rising edge.
  task automatic wait_for(input bit on_ack);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((on_ack ? ack_valid : pready) !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail("handshake timeout");
      complete_run();
    end
  endtask
  // One APB transfer: setup, then access held until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    wait_for(1'b0);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Send one message, compare the answer, then service the watchdog.
  task automatic msg(input logic [7:0] t);
    e = model(t);
    send      <= 1'b1;
    send_type <= t;
    @(posedge mclk);
    send <= 1'b0;
    wait_for(1'b1);
    cmp_ack(e);
    apb(1'b1, health_pkg::OFF_WDOG, 32'h00000001);
    wdog_bad = 1'b0;
  endtask
  task automatic set_mode(input int m);
    mode = m;
    apb(1'b1, health_pkg::OFF_CTRL, {alt, 13'h0000, alt_int, 2'(m)});
  endtask
  // Change every pin but the fix line and let the synchronisers settle.
  task automatic set_pins(input logic [9:0] v);
    pins[9:3] <= v[9:3];
    pins[1:0] <= v[1:0];
    repeat (8) @(posedge mclk);
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    mode = 0;
    {pu_fail, cpu_ok, wdog_bad, addr_ok, alt_int, alt, pu_w} = '0;
    @(posedge mclk);
  endtask
  initial begin
    void'($urandom(7688));
    do_reset();
    apb(1'b1, health_pkg::OFF_ADDRESS, $urandom_range(32'h00FFFFFE, 1));
    addr_ok = 1'b1;
    for (int m = 0; m < 4; m++) begin
      alt     = 16'($urandom);
      alt_int = 1'($urandom);
      set_mode(m);
      set_pins({7'h73, 1'b0, 2'($urandom)});
      msg(8'h01);
      msg(health_pkg::MSG_STATUS_REQ);
    end
    $display("test mode sweep done");
    apb(1'b1, health_pkg::OFF_CPU_RES, health_pkg::CPU_EXPECTED);
    apb(1'b1, health_pkg::OFF_POWERUP, 32'h0000007F);
    {cpu_ok, pu_w} = {1'b1, 7'h7F};
    msg(health_pkg::MSG_STATUS_REQ);
    for (int k = 3; k < 10; k++) begin
      if (k == 5 || k == 6) exp_resets++;
      set_pins(pins ^ (10'h001 << k));
      msg(health_pkg::MSG_STATUS_REQ);
      set_mode(0);
      msg(8'h02);
      set_mode(3);
      set_pins(pins ^ (10'h001 << k));
      msg(health_pkg::MSG_STATUS_REQ);
    end
    $display("test continuous faults done");
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, health_pkg::OFF_ADDRESS, a ? 32'h00FFFFFF : 32'h00000000);
      addr_ok = 1'b0;
      msg(8'h03);
    end
    apb(1'b1, health_pkg::OFF_ADDRESS, 32'h00123456);
    addr_ok = 1'b1;
    gps_on  = 1'b0;
    repeat (GPS_T + 100) @(posedge mclk);
    gps_lost = 1'b1;
    msg(8'h04);
    gps_on = 1'b1;
    repeat (200) @(posedge mclk);
    gps_lost = 1'b0;
    msg(8'h04);
    repeat (WDOG_T + 50) @(posedge mclk);
    {wdog_bad, exp_resets} = {1'b1, exp_resets + 1};
    msg(health_pkg::MSG_STATUS_REQ);
    $display("test system faults and watchdog done");
    apb(1'b1, health_pkg::OFF_POWERUP, 32'h0000003F);
    {pu_w, pu_fail} = {7'h3F, 1'b1};
    msg(health_pkg::MSG_STATUS_REQ);
    e = model(health_pkg::MSG_STATUS_REQ);
    apb(1'b0, health_pkg::OFF_ACK_STAT, 32'h00000000);
    cmp(rdata, {22'h000000, e.unit_fail_flag, e.sys_fail, e.selftest_byte_zero}, "status");
    apb(1'b0, 8'h40, 32'h00000000);
    cmp({rdata[30:0], rerr}, 32'h00000001, "unmapped read");
    cmp(resets, exp_resets, "processor resets");
    do_reset();
    set_mode(2);
    msg(health_pkg::MSG_STATUS_REQ);
    apb(1'b1, health_pkg::OFF_CPU_RES, ~health_pkg::CPU_EXPECTED);
    pu_fail = 1'b1;
    msg(health_pkg::MSG_STATUS_REQ);
    $display("test power-up latch done");
    complete_run();
  end
endmodule
